// >>> common/relay_pkg.sv
/*
  Constants, codes and states shared by the cascade frame relay.
  Assumes the link stream is sampled on the rising edge of the link clock.
*/
// Operation
// RL1 - Tail of any length follows all sets; relayed onward, last stage returns it.
// RL2 - Tail bits are never captured as this stage's own data.
// RL3 - Trim set is blue, green, red bytes: 24 bits per stage.
// RL4 - Host sends each intensity byte three times, 24 bits per stage.
// RL5 - Host sends each configuration byte three times, 24 bits per stage.
// RL6 - Unmuxed duty set: 24 values of 12 or 14 bits, blue 7 to red 0.
// RL7 - Muxed duty set: first-phase value then second-phase value per output.
// RL8 - Every duty value travels most significant bit first.
// RL9 - Capture the first set after the header; its length follows the command.
// RL10 - Own set is not forwarded; 24-bit sets give header output 25 cycles on.
// RL11 - Later sets and tail leave one link cycle after arrival.
// RL12 - Header lags input by set length plus one cycle.
// RL13 - Host compares the returned tail with the one it sent.
// RL14 - Codes 01 and 11 count open outputs; 00 and 10 count overtemperature.
// RL15 - Selected fault present: add one to the received 10-bit counter.
// RL16 - Any number of open outputs adds exactly one.
// RL17 - Overtemperature forces all duty values to zero until it clears.
// RL18 - No selected fault: counter passes on unchanged.
// RL19 - Header is sync byte, six command bits, ten counter bits.
// RL20 - Two command bits sent three times pick one of four loads.
// RL21 - Sample data and load, and update outputs, on rising link edges.
// RL22 - Search sync while load low; load rises within a cycle of command.
// RL23 - Load output rises with the regenerated header's first command bit.
// RL24 - Stored values change only when a whole set has arrived.
package relay_pkg;
  localparam logic [7:0] SYNC_PATTERN = 8'he8;
  localparam int CNT_BITS = 10;
  localparam int HEAD_BITS = 24;
  localparam int SET_BITS = 24;
  localparam int BYTE_BITS = 8;
  localparam int CHANNELS = 24;
  localparam int POS_BITS = 11;
  localparam int PWM_WIDTH_SHORT = 12;
  localparam int PWM_WIDTH_LONG = 14;
  localparam int CFG_MUX_BIT = 0;
  localparam int TRIM_BLUE_LSB = 16;
  localparam int TRIM_GREEN_LSB = 8;
  localparam int TRIM_RED_LSB = 0;
  localparam logic [10:0] POS_CMD_FIRST = 11'h008;
  localparam logic [10:0] POS_LOAD_LATEST = 11'h009;
  localparam logic [10:0] POS_CMD_LAST = 11'h00d;
  localparam logic [10:0] POS_HEAD_LAST = 11'h017;
  localparam logic [10:0] LOAD_OUT_LAG = 11'h008;
  localparam logic [9:0] CNT_ONE = 10'h001;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] INTENSITY_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  typedef enum logic [1:0] {
    CMD_PWM = 2'h0,
    CMD_TRIM = 2'h1,
    CMD_INTENSITY = 2'h2,
    CMD_CONFIG = 2'h3
  } cmd_e;
  typedef enum logic [3:0] {
    ST_SEARCH = 4'h1,
    ST_HEAD = 4'h2,
    ST_CAPT = 4'h4,
    ST_RELAY = 4'h8
  } link_state_e;
endpackage

// >>> hdl/level_sync.sv
/*
  Two-stage synchroniser for slow levels and toggles.
  Assumes inputs change no faster than the destination clock can see.
*/
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,               // Destination clock
  input wire logic nrst_in,              // Async reset, active low
  input wire logic [WIDTH-1:0] async_in, // Foreign-domain levels
  output logic [WIDTH-1:0] sync_out      // Synchronised levels
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  always_comb begin
    st_next.first = async_in;
    st_next.second = st_reg.first;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.second;
endmodule

// >>> hdl/cascade_frame_relay.sv
/*
  One stage of the cascaded LED driver link: finds the header, captures
  its own data set, sends a regenerated header with the fault counter and
  relays later sets and the tail. Captured sets are committed to storage
  in the system clock domain.
  Assumes the link clock runs while frames pass and that data and load
  arrive synchronous to it; fault inputs are asynchronous levels.
*/
`timescale 1ns/1ps
module cascade_frame_relay #(
  parameter int PWM_WIDTH = 12
) (
  input wire logic sys_clk_in,             // System clock, 40 MHz
  input wire logic nrst_in,                // Async reset, active low
  input wire logic link_clock_in,          // Link clock from upstream
  input wire logic serial_data_in,         // Serial stream from upstream
  input wire logic frame_load_in,          // Frame load from upstream
  input wire logic open_output_fault_in,   // Any output open, async level
  input wire logic overtemp_fault_in,      // Die overtemperature, async level
  output logic serial_data_out,            // Serial stream downstream
  output logic frame_load_out,             // Frame load downstream
  output logic [7:0] bank_current_trim_blue_out,  // Blue bank trim
  output logic [7:0] bank_current_trim_green_out, // Green bank trim
  output logic [7:0] bank_current_trim_red_out,   // Red bank trim
  output logic [7:0] global_intensity_value_out,  // Global intensity
  output logic [7:0] config_out,                  // Configuration byte
  output logic [relay_pkg::CHANNELS*PWM_WIDTH-1:0] duty_mux_phase_first_out,  // Duties
  output logic [relay_pkg::CHANNELS*PWM_WIDTH-1:0] duty_mux_phase_second_out  // Duties
);
  // ==========================================================
  // Sizes
  localparam int CH = relay_pkg::CHANNELS;
  localparam int PB = relay_pkg::POS_BITS;
  localparam int BB = relay_pkg::BYTE_BITS;
  localparam int MAX_BITS = 2 * CH * PWM_WIDTH;
  localparam logic [PB-1:0] LEN_SET = PB'(relay_pkg::SET_BITS);
  localparam logic [PB-1:0] LEN_SINGLE = PB'(CH * PWM_WIDTH);
  localparam logic [PB-1:0] LEN_DOUBLE = PB'(MAX_BITS);

  if (PWM_WIDTH != relay_pkg::PWM_WIDTH_SHORT &&
      PWM_WIDTH != relay_pkg::PWM_WIDTH_LONG) begin : g_bad_width
    $error("PWM_WIDTH must be 12 or 14");
  end

  // ==========================================================
  // Link domain state
  typedef struct packed {
    relay_pkg::link_state_e state;
    logic lprev;
    logic [7:0] sync_sr;
    logic [PB-1:0] pos;
    logic [relay_pkg::HEAD_BITS-1:0] head;
    relay_pkg::cmd_e cmd;
    logic [PB-1:0] len;
    logic cap_mux;
    logic [MAX_BITS-1:0] data;
    logic done_tgl;
    logic dout;
    logic lout;
  } link_s;

  // ==========================================================
  // System domain state
  typedef struct packed {
    logic tg_seen;
    logic [7:0] trim_b;
    logic [7:0] trim_g;
    logic [7:0] trim_r;
    logic [7:0] intensity;
    logic [7:0] cfg;
    logic [CH-1:0][PWM_WIDTH-1:0] duty_a;
    logic [CH-1:0][PWM_WIDTH-1:0] duty_b;
    logic [CH-1:0][PWM_WIDTH-1:0] out_a;
    logic [CH-1:0][PWM_WIDTH-1:0] out_b;
  } sys_s;

  link_s lk_reg;
  link_s lk_next;
  sys_s sy_reg;
  sys_s sy_next;

  logic [2:0] lk_sync;
  logic [1:0] sy_sync;
  logic mux_lk;
  logic open_lk;
  logic ot_lk;
  logic tg_sys;
  logic ot_sys;
  logic fault_sel;
  logic commit_go;
  logic [7:0] sync_win;
  logic [relay_pkg::CNT_BITS-1:0] cnt_rx;
  logic [CH-1:0][PWM_WIDTH-1:0] single_w;
  logic [CH-1:0][PWM_WIDTH-1:0] first_w;
  logic [CH-1:0][PWM_WIDTH-1:0] second_w;

  // ==========================================================
  // Crossings
  level_sync #(.WIDTH(3)) u_link_sync (
    .clk_in(link_clock_in),
    .nrst_in(nrst_in),
    .async_in({sy_reg.cfg[relay_pkg::CFG_MUX_BIT], open_output_fault_in,
               overtemp_fault_in}),
    .sync_out(lk_sync)
  );

  level_sync #(.WIDTH(2)) u_sys_sync (
    .clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .async_in({lk_reg.done_tgl, overtemp_fault_in}),
    .sync_out(sy_sync)
  );

  assign {mux_lk, open_lk, ot_lk} = lk_sync;
  assign {tg_sys, ot_sys} = sy_sync;

  // ==========================================================
  // Link framing
  // Odd command codes count open outputs, even ones overtemperature
  assign fault_sel = lk_reg.cmd[0] ? open_lk : ot_lk;  // RL14 RL16
  assign sync_win = {lk_reg.sync_sr[6:0], serial_data_in};
  assign cnt_rx = {lk_reg.head[relay_pkg::CNT_BITS-2:0], serial_data_in};

  always_comb begin
    lk_next = lk_reg;
    lk_next.lprev = frame_load_in;
    lk_next.sync_sr = sync_win;
    lk_next.dout = 1'b0;
    lk_next.lout = 1'b0;
    case (lk_reg.state)
      relay_pkg::ST_SEARCH: begin
        // Load seen low on the edge before the last sync bit
        if (!lk_reg.lprev && sync_win == relay_pkg::SYNC_PATTERN) begin  // RL22
          lk_next.state = relay_pkg::ST_HEAD;
          lk_next.pos = relay_pkg::POS_CMD_FIRST;
        end
      end
      relay_pkg::ST_HEAD: begin
        lk_next.pos = lk_reg.pos + PB'(1);
        lk_next.head = {lk_reg.head[relay_pkg::HEAD_BITS-2:0], serial_data_in};
        if (!frame_load_in && lk_reg.pos >= relay_pkg::POS_LOAD_LATEST) begin  // RL22
          lk_next.state = relay_pkg::ST_SEARCH;
        end else if (lk_reg.pos == relay_pkg::POS_CMD_LAST) begin
          lk_next.cmd = relay_pkg::cmd_e'({lk_reg.head[0], serial_data_in});  // RL20
        end else if (lk_reg.pos == relay_pkg::POS_HEAD_LAST) begin
          // Sync, received command, counter plus at most one
          lk_next.head = {relay_pkg::SYNC_PATTERN, lk_reg.head[14:9],
                         cnt_rx + relay_pkg::CNT_BITS'(fault_sel)};  // RL15 RL18 RL19
          lk_next.cap_mux = mux_lk;
          if (lk_reg.cmd == relay_pkg::CMD_PWM) begin  // RL9
            lk_next.len = mux_lk ? LEN_DOUBLE : LEN_SINGLE;
          end else begin
            lk_next.len = LEN_SET;
          end
          lk_next.state = relay_pkg::ST_CAPT;
        end
      end
      relay_pkg::ST_CAPT: begin
        lk_next.pos = lk_reg.pos + PB'(1);
        lk_next.data = {lk_reg.data[MAX_BITS-2:0], serial_data_in};  // RL8
        // Header leaves after len bits, so output lags by len plus one
        if (lk_reg.pos >= lk_reg.len) begin  // RL10 RL12
          lk_next.dout = lk_reg.head[relay_pkg::HEAD_BITS-1];
          lk_next.head = {lk_reg.head[relay_pkg::HEAD_BITS-2:0], 1'b0};
        end
        lk_next.lout = lk_reg.pos >= lk_reg.len + relay_pkg::LOAD_OUT_LAG;  // RL23
        if (!frame_load_in) begin
          lk_next.state = relay_pkg::ST_SEARCH;
          lk_next.dout = 1'b0;
          lk_next.lout = 1'b0;
        end else if (lk_reg.pos == relay_pkg::POS_HEAD_LAST + lk_reg.len) begin
          // Set is whole; capture stops here so the tail is never taken
          lk_next.state = relay_pkg::ST_RELAY;  // RL2
          lk_next.done_tgl = ~lk_reg.done_tgl;  // RL24
        end
      end
      relay_pkg::ST_RELAY: begin
        lk_next.dout = serial_data_in;  // RL1 RL11
        lk_next.lout = frame_load_in;
        if (!frame_load_in) begin
          lk_next.state = relay_pkg::ST_SEARCH;
        end
      end
      default: begin
        lk_next.state = relay_pkg::ST_SEARCH;
      end
    endcase
  end

  always_ff @(posedge link_clock_in or negedge nrst_in) begin  // RL21
    if (!nrst_in) begin
      lk_reg <= '{state: relay_pkg::ST_SEARCH, cmd: relay_pkg::CMD_PWM, default: '0};
    end else begin
      lk_reg <= lk_next;
    end
  end

  assign serial_data_out = lk_reg.dout;
  assign frame_load_out = lk_reg.lout;

  // ==========================================================
  // Commit of captured sets
  // The captured set stays still until the next frame reaches its data,
  // at least a header's length of link cycles, far longer than the crossing.
  for (genvar ch = 0; ch < CH; ch++) begin : g_ch
    assign single_w[ch] = lk_reg.data[ch*PWM_WIDTH +: PWM_WIDTH];  // RL6
    assign first_w[ch] = lk_reg.data[(2*ch+1)*PWM_WIDTH +: PWM_WIDTH];  // RL7
    assign second_w[ch] = lk_reg.data[2*ch*PWM_WIDTH +: PWM_WIDTH];
  end

  // Three copies per bit; a single flipped bit is outvoted
  function automatic logic [7:0] vote3(input logic [23:0] v);
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    a = v[relay_pkg::TRIM_BLUE_LSB +: BB];
    b = v[relay_pkg::TRIM_GREEN_LSB +: BB];
    c = v[relay_pkg::TRIM_RED_LSB +: BB];
    vote3 = (a & b) | (a & c) | (b & c);
  endfunction

  assign commit_go = tg_sys != sy_reg.tg_seen;

  always_comb begin
    sy_next = sy_reg;
    sy_next.tg_seen = tg_sys;
    if (commit_go) begin  // RL24
      case (lk_reg.cmd)
        relay_pkg::CMD_TRIM: begin
          sy_next.trim_b = lk_reg.data[relay_pkg::TRIM_BLUE_LSB +: BB];  // RL3
          sy_next.trim_g = lk_reg.data[relay_pkg::TRIM_GREEN_LSB +: BB];
          sy_next.trim_r = lk_reg.data[relay_pkg::TRIM_RED_LSB +: BB];
        end
        relay_pkg::CMD_INTENSITY: begin
          sy_next.intensity = vote3(lk_reg.data[relay_pkg::SET_BITS-1:0]);  // RL4
        end
        relay_pkg::CMD_CONFIG: begin
          sy_next.cfg = vote3(lk_reg.data[relay_pkg::SET_BITS-1:0]);  // RL5
        end
        relay_pkg::CMD_PWM: begin
          if (lk_reg.cap_mux) begin
            sy_next.duty_a = first_w;
            sy_next.duty_b = second_w;
          end else begin
            sy_next.duty_a = single_w;
          end
        end
        default: begin
          sy_next.tg_seen = tg_sys;
        end
      endcase
    end
    // Stored duties survive the fault and return when it clears
    sy_next.out_a = ot_sys ? '0 : sy_reg.duty_a;  // RL17
    sy_next.out_b = ot_sys ? '0 : sy_reg.duty_b;
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sy_reg <= '{trim_b: relay_pkg::TRIM_RESET, trim_g: relay_pkg::TRIM_RESET,
                  trim_r: relay_pkg::TRIM_RESET, intensity: relay_pkg::INTENSITY_RESET,
                  cfg: relay_pkg::CONFIG_RESET, default: '0};
    end else begin
      sy_reg <= sy_next;
    end
  end

  assign bank_current_trim_blue_out = sy_reg.trim_b;
  assign bank_current_trim_green_out = sy_reg.trim_g;
  assign bank_current_trim_red_out = sy_reg.trim_r;
  assign global_intensity_value_out = sy_reg.intensity;
  assign config_out = sy_reg.cfg;
  assign duty_mux_phase_first_out = sy_reg.out_a;
  assign duty_mux_phase_second_out = sy_reg.out_b;

  // ==========================================================
  // Checks
  sequence s_emit_go;
    lk_reg.state == relay_pkg::ST_CAPT && lk_reg.pos == lk_reg.len && frame_load_in;
  endsequence

  sequence s_head_end;
    lk_reg.state == relay_pkg::ST_HEAD && lk_reg.pos == relay_pkg::POS_HEAD_LAST &&
      frame_load_in;
  endsequence

  property p_relay;
    @(posedge link_clock_in) disable iff (!nrst_in)
      (lk_reg.state == relay_pkg::ST_RELAY && frame_load_in) |=>
        serial_data_out == $past(serial_data_in);
  endproperty
  AST_RELAY_ONE_CYCLE: assert property (p_relay)  // RL11
    else $error("relayed bit not one cycle late");

  property p_quiet;
    @(posedge link_clock_in) disable iff (!nrst_in)
      (lk_reg.state == relay_pkg::ST_CAPT && lk_reg.pos < lk_reg.len) |=>
        !serial_data_out;
  endproperty
  AST_OWN_SET_HIDDEN: assert property (p_quiet)  // RL10
    else $error("own data leaked downstream");

  property p_sync_out;
    @(posedge link_clock_in) disable iff (!nrst_in)
      (s_emit_go ##0 frame_load_in [*3]) |=>
        $past(serial_data_out, 2) && $past(serial_data_out) && serial_data_out;
  endproperty
  AST_HEADER_START: assert property (p_sync_out)  // RL12
    else $error("header did not start after set length");

  property p_load_out;
    @(posedge link_clock_in) disable iff (!nrst_in)
      (lk_reg.state == relay_pkg::ST_CAPT && frame_load_in &&
       lk_reg.pos == lk_reg.len + relay_pkg::LOAD_OUT_LAG) |=> $rose(frame_load_out);
  endproperty
  AST_LOAD_OUT_RISE: assert property (p_load_out)  // RL23
    else $error("load output not aligned with command");

  property p_cnt_copy;
    @(posedge link_clock_in) disable iff (!nrst_in)
      (s_head_end ##0 !fault_sel) |=> lk_reg.head[relay_pkg::CNT_BITS-1:0] == $past(cnt_rx);
  endproperty
  AST_COUNT_COPY: assert property (p_cnt_copy)  // RL18
    else $error("counter altered without fault");

  property p_cnt_inc;
    @(posedge link_clock_in) disable iff (!nrst_in)
      (s_head_end ##0 fault_sel) |=>
        lk_reg.head[relay_pkg::CNT_BITS-1:0] == $past(cnt_rx) + relay_pkg::CNT_ONE;
  endproperty
  AST_COUNT_INC: assert property (p_cnt_inc)  // RL15
    else $error("counter not raised by one");

  property p_abort;
    @(posedge link_clock_in) disable iff (!nrst_in)
      (lk_reg.state == relay_pkg::ST_HEAD && !frame_load_in &&
       lk_reg.pos >= relay_pkg::POS_LOAD_LATEST) |=>
        lk_reg.state == relay_pkg::ST_SEARCH && !frame_load_out;
  endproperty
  AST_LATE_LOAD_ABORT: assert property (p_abort)  // RL22
    else $error("frame kept without load");

  property p_commit;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      $changed(bank_current_trim_blue_out) |-> $past(commit_go);
  endproperty
  AST_COMMIT_WHOLE: assert property (p_commit)  // RL24
    else $error("trim changed without a complete set");

  property p_blank;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      ot_sys |=> duty_mux_phase_first_out == '0 && duty_mux_phase_second_out == '0;
  endproperty
  AST_OVERTEMP_BLANK: assert property (p_blank)  // RL17
    else $error("duties not forced off");
endmodule

// >>> bench/link_host.sv
/*
  Upstream link partner: builds frames, clocks them into one relay stage and
  records what the stage sends downstream, one sample per rising link edge.
  Assumes the bench fills tx with the data sets before calling send.
*/
`timescale 1ns/1ps
module link_host (
  output logic link_clk_out, // Link clock, runs only around frames
  output logic data_out,     // Serial stream to the stage
  output logic load_out,     // Frame load to the stage
  input wire logic dout_in,  // Stream back from the stage
  input wire logic lout_in   // Load back from the stage
);
  logic tx[$];
  logic rx[$];
  logic lrx[$];
  int total;

  initial begin
    link_clk_out = 1'b0;
    data_out = 1'b0;
    load_out = 1'b0;
  end

  // ==========================================================
  // Edge driver
  // Inputs move in the low phase, half a period from the sampling edge
  task automatic edge_step(input logic d, input logic l, input logic rec);
    if (rec) begin
      rx.push_back(dout_in);
      lrx.push_back(lout_in);
    end
    data_out = d;
    load_out = l;
    #80;
    link_clk_out = 1'b1;
    #80;
    link_clk_out = 1'b0;
  endtask

  task automatic idle(input int n);
    for (int k = 0; k < n; k++) edge_step(1'b0, 1'b0, 1'b0);
  endtask

  // ==========================================================
  // Frame sender
  // Header goes in front of the sets, a patterned tail behind them
  task automatic send(input logic [1:0] cmd, input logic [9:0] cnt, input int tail_len,
                      input int abort_at);
    logic [23:0] head;
    head = {relay_pkg::SYNC_PATTERN, {3{cmd}}, cnt};
    for (int i = 0; i < 24; i++) tx.push_front(head[i]);
    for (int i = 0; i < tail_len; i++) tx.push_back(i % 3 == 0);
    total = tx.size();
    rx.delete();
    lrx.delete();
    idle(3);
    for (int k = 0; k < total && k != abort_at; k++) edge_step(tx[k], k >= 8, 1'b1);
    // Released line toggles so a stale bit cannot pass for data
    for (int k = 0; k < 4; k++) edge_step(k[0], 1'b0, 1'b1);
  endtask
endmodule

// >>> bench/tb.sv
/*
  Self-checking bench for one relay stage: frames of every command pass
  through, header, counter, relay timing and stored values are judged.
  Assumes link_host drives the link and nothing else touches the stage.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  localparam int W = 12;
  logic sys_clk_in;
  logic nrst_in;
  logic link_clock_in;
  logic serial_data_in;
  logic frame_load_in;
  logic open_output_fault_in;
  logic overtemp_fault_in;
  logic serial_data_out;
  logic frame_load_out;
  logic [7:0] trim_b;
  logic [7:0] trim_g;
  logic [7:0] trim_r;
  logic [7:0] inten;
  logic [7:0] cfg;
  logic [relay_pkg::CHANNELS*W-1:0] duty1;
  logic [relay_pkg::CHANNELS*W-1:0] duty2;
  int num_errors;
  int total_checks;

  cascade_frame_relay #(.PWM_WIDTH(W)) u_cascade_frame_relay (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .link_clock_in(link_clock_in),
    .serial_data_in(serial_data_in), .frame_load_in(frame_load_in),
    .open_output_fault_in(open_output_fault_in), .overtemp_fault_in(overtemp_fault_in),
    .serial_data_out(serial_data_out), .frame_load_out(frame_load_out),
    .bank_current_trim_blue_out(trim_b), .bank_current_trim_green_out(trim_g),
    .bank_current_trim_red_out(trim_r), .global_intensity_value_out(inten),
    .config_out(cfg), .duty_mux_phase_first_out(duty1), .duty_mux_phase_second_out(duty2));

  link_host u_link_host (
    .link_clk_out(link_clock_in), .data_out(serial_data_in), .load_out(frame_load_in),
    .dout_in(serial_data_out), .lout_in(frame_load_out));

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // ==========================================================
  // Helpers
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic push_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) u_link_host.tx.push_back(v[i]);
  endtask

  task automatic set_faults(input logic open_f, input logic hot_f);
    @(negedge sys_clk_in);
    open_output_fault_in = open_f;
    overtemp_fault_in = hot_f;
    repeat (4) @(negedge sys_clk_in);
  endtask

  // Header lands set length plus one edge late; later bits one edge late
  task automatic check_frame(input int len, input logic [1:0] cmd, input logic [9:0] cnt);
    logic [23:0] head;
    head = {relay_pkg::SYNC_PATTERN, {3{cmd}}, cnt};
    for (int j = 0; j < 24; j++) begin
      `CHK("header bit", head[23-j], u_link_host.rx[len+1+j])
    end
    `CHK("load out early", 1'b0, u_link_host.lrx[len+8])
    `CHK("load out", 1'b1, u_link_host.lrx[len+9])
    for (int k = 24 + len; k < u_link_host.total; k++) begin
      `CHK("relay bit", u_link_host.tx[k], u_link_host.rx[k+1])
    end
    repeat (4) @(negedge sys_clk_in);
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_trim;
    set_faults(1'b0, 1'b0);
    u_link_host.tx.delete();
    push_byte(8'h81);
    push_byte(8'h3c);
    push_byte(8'h5a);
    u_link_host.send(relay_pkg::CMD_TRIM, 10'h000, 20, -1);
    check_frame(24, relay_pkg::CMD_TRIM, 10'h000);
    `CHK("trim blue", 8'h81, trim_b)
    `CHK("trim green", 8'h3c, trim_g)
    `CHK("trim red", 8'h5a, trim_r)
    $display("test trim done");
  endtask

  task automatic test_intensity;
    set_faults(1'b0, 1'b1);
    u_link_host.tx.delete();
    repeat (3) push_byte(8'hc3);
    u_link_host.send(relay_pkg::CMD_INTENSITY, 10'h005, 9, -1);
    check_frame(24, relay_pkg::CMD_INTENSITY, 10'h006);
    `CHK("intensity", 8'hc3, inten)
    set_faults(1'b0, 1'b0);
    $display("test intensity done");
  endtask

  task automatic test_config;
    set_faults(1'b1, 1'b0);
    u_link_host.tx.delete();
    repeat (3) push_byte(8'h0a);
    u_link_host.send(relay_pkg::CMD_CONFIG, 10'h3fe, 5, -1);
    check_frame(24, relay_pkg::CMD_CONFIG, 10'h3ff);
    `CHK("config", 8'h0a, cfg)
    $display("test config done");
  endtask

  // Unmuxed duties: first value received belongs to channel 23
  task automatic test_pwm;
    logic [W-1:0] v;
    set_faults(1'b1, 1'b0);
    u_link_host.tx.delete();
    for (int n = 0; n < relay_pkg::CHANNELS; n++) begin
      v = 12'h800 | W'(n);
      for (int i = W - 1; i >= 0; i--) u_link_host.tx.push_back(v[i]);
    end
    u_link_host.send(relay_pkg::CMD_PWM, 10'h009, 8, -1);
    check_frame(relay_pkg::CHANNELS * W, relay_pkg::CMD_PWM, 10'h009);
    `CHK("duty ch23", 12'h800, duty1[23*W +: W])
    `CHK("duty ch0", 12'h817, duty1[0 +: W])
    `CHK("duty phase two", '0, duty2)
    set_faults(1'b0, 1'b1);
    `CHK("duty blanked", '0, duty1)
    set_faults(1'b0, 1'b0);
    `CHK("duty restored", 12'h800, duty1[23*W +: W])
    $display("test pwm done");
  endtask

  // Muxed duties: config bit 0 doubles the set, phases alternate per output
  task automatic test_pwm_mux;
    logic [W-1:0] v;
    u_link_host.tx.delete();
    repeat (3) push_byte(8'h0b);
    u_link_host.send(relay_pkg::CMD_CONFIG, 10'h000, 0, -1);
    check_frame(24, relay_pkg::CMD_CONFIG, 10'h000);
    `CHK("config mux", 8'h0b, cfg)
    u_link_host.tx.delete();
    for (int n = 0; n < 2 * relay_pkg::CHANNELS; n++) begin
      v = 12'h400 | W'(n);
      for (int i = W - 1; i >= 0; i--) u_link_host.tx.push_back(v[i]);
    end
    u_link_host.send(relay_pkg::CMD_PWM, 10'h001, 4, -1);
    check_frame(2 * relay_pkg::CHANNELS * W, relay_pkg::CMD_PWM, 10'h001);
    `CHK("mux ch23 first", 12'h400, duty1[23*W +: W])
    `CHK("mux ch23 second", 12'h401, duty2[23*W +: W])
    `CHK("mux ch0 first", 12'h42e, duty1[0 +: W])
    `CHK("mux ch0 second", 12'h42f, duty2[0 +: W])
    $display("test pwm mux done");
  endtask

  // Load falls in the header, then inside the own set: nothing may be stored
  task automatic test_abort;
    for (int c = 0; c < 2; c++) begin
      u_link_host.tx.delete();
      repeat (3) push_byte(8'hff);
      u_link_host.send(relay_pkg::CMD_TRIM, 10'h000, 0, c ? 30 : 11);
      repeat (4) @(negedge sys_clk_in);
      `CHK("abort blue", 8'h81, trim_b)
      `CHK("abort red", 8'h5a, trim_r)
      `CHK("abort load out", 1'b0, frame_load_out)
    end
    $display("test abort done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    #2000000;
    num_errors++;
    wrap_up();
  end

  initial begin
    num_errors = 0;
    total_checks = 0;
    nrst_in = 1'b0;
    open_output_fault_in = 1'b0;
    overtemp_fault_in = 1'b0;
    // Link edges during reset let its synchronisers clear too
    u_link_host.idle(2);
    repeat (5) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    `CHK("reset trim", 8'h00, trim_b)
    `CHK("reset duty", '0, duty1)
    test_trim();
    test_intensity();
    test_config();
    test_pwm();
    test_pwm_mux();
    test_abort();
    wrap_up();
  end
endmodule
